// File: rtm_ctrl.sv
// Purpose: controller end; runs a training pass over the command link
// Assumes: banks idle when start pulses
// Notes:   sweep and midpoint choice, with the required waits
`timescale 1ns/1ps
`include "rtm_consts.svh"
module rtm_ctrl (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // command link
  rtm_if.ctrl             link,
  // user side
  input  wire logic       start,
  input  wire logic       range_sel,
  input  wire logic       per_device_addressing,
  input  wire logic       pass_in,
  output logic            busy,
  output logic            done,
  output logic [5:0]      final_code
);
  typedef enum logic [2:0] {S_IDLE, S_ENTRY, S_SET, S_WAIT, S_TEST,
                            S_FINAL, S_EXIT, S_XWAIT} rtm_st_type;
  rtm_st_type  st_q, st_d;
  logic [5:0]  code_q, code_d, lo_q, lo_d, hi_q, hi_d, fin_q, fin_d;
  logic        seen_q, seen_d, rng_q, rng_d, done_q, done_d;
  logic [5:0]  cnt_q, cnt_d;
  rtm_pkg::rtm_cmd_type cmd_d, cmd_q;
  logic [7:0]  dat_d, dat_q;

  function automatic logic [5:0] settle(input logic [5:0] a, input logic [5:0] b);
    settle = ((a > b ? a - b : b - a) >= `RTM_BIG_STEP) ?
             6'(`RTM_SETTLE_L_CYC) : 6'(`RTM_SETTLE_S_CYC);
  endfunction : settle

  // sequencer: entry, sweep, final write, exit
  always_comb
  begin
    st_d   = st_q;
    code_d = code_q;
    lo_d   = lo_q;
    hi_d   = hi_q;
    fin_d  = fin_q;
    seen_d = seen_q;
    rng_d  = rng_q;
    done_d = 1'b0;
    cnt_d = (cnt_q != 6'h00) ? cnt_q - 6'h01 : 6'h00;
    cmd_d = rtm_pkg::RTM_CMD_DES;
    dat_d = 8'h00;
    unique case (st_q)
      S_IDLE:
        if (start)
        begin
          rng_d = range_sel;
          cmd_d = rtm_pkg::RTM_CMD_MRS;
          dat_d = {1'b1, range_sel, 6'h00};
          cnt_d = 6'(`RTM_ENTRY_CYC);
          code_d = 6'h00;
          seen_d = 1'b0;
          st_d = S_ENTRY;
        end
      S_ENTRY: if (cnt_q == 6'h00) st_d = S_SET;
      S_SET:
      begin
        cmd_d = rtm_pkg::RTM_CMD_MRS;
        dat_d = {1'b1, rng_q, code_q};
        cnt_d = settle(code_q, code_q - 6'h01);
        st_d = S_WAIT;
      end
      S_WAIT: if (cnt_q == 6'h00) st_d = S_TEST;
      S_TEST:
      begin
        // with per-device addressing only mode writes go out
        if (!per_device_addressing)
          cmd_d = rtm_pkg::RTM_CMD_RD;
        if (pass_in && !per_device_addressing)
        begin
          if (!seen_q)
            lo_d = code_q;
          hi_d   = code_q;
          seen_d = 1'b1;
        end
        if (code_q == `RTM_CODE_MAX)
          st_d = S_FINAL;
        else
        begin
          code_d = code_q + 6'h01;
          st_d   = S_SET;
        end
      end
      S_FINAL:
      begin
        fin_d = seen_q ? 6'((7'(lo_q) + 7'(hi_q)) >> 1) : 6'h00;
        cmd_d = rtm_pkg::RTM_CMD_MRS;
        dat_d = {1'b1, rng_q, fin_d};
        cnt_d = 6'(`RTM_SETTLE_L_CYC);
        st_d = S_EXIT;
      end
      S_EXIT:
        if (cnt_q == 6'h00)
        begin
          cmd_d = rtm_pkg::RTM_CMD_MRS;
          dat_d = {1'b0, rng_q, 6'h00};
          cnt_d = 6'(`RTM_EXIT_CYC);
          st_d = S_XWAIT;
        end
      S_XWAIT:
        if (cnt_q == 6'h00)
        begin
          done_d = 1'b1;
          st_d   = S_IDLE;
        end
    endcase
  end

  // registers
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      st_q   <= S_IDLE;
      code_q <= 6'h00;
      lo_q   <= 6'h00;
      hi_q   <= 6'h00;
      fin_q  <= 6'h00;
      seen_q <= 1'b0;
      rng_q  <= 1'b0;
      done_q <= 1'b0;
      cnt_q  <= 6'h00;
      cmd_q  <= rtm_pkg::RTM_CMD_DES;
      dat_q  <= 8'h00;
    end
    else
    begin
      st_q   <= st_d;
      code_q <= code_d;
      lo_q   <= lo_d;
      hi_q   <= hi_d;
      fin_q  <= fin_d;
      seen_q <= seen_d;
      rng_q  <= rng_d;
      done_q <= done_d;
      cnt_q  <= cnt_d;
      cmd_q  <= cmd_d;
      dat_q  <= dat_d;
    end
  end

  assign link.cmd                   = cmd_q;
  assign link.mrs_data              = dat_q;
  assign link.per_device_addressing = per_device_addressing;
  assign busy                       = (st_q != S_IDLE);
  assign done                       = done_q;
  assign final_code                 = fin_q;
endmodule : rtm_ctrl

// File: rtm_consts.svh
// Purpose: constants for the reference training mode ends
// Assumes: 125 MHz sys_clk
// Notes:   field positions of the training mode register image
`ifndef RTM_CONSTS_SVH
`define RTM_CONSTS_SVH
`define RTM_EN_BIT        7
`define RTM_RANGE_BIT     6
`define RTM_VAL_MSB       5
`define RTM_CODE_MAX      6'h32
`define RTM_CLK_PS        8000
`define RTM_ENTRY_NS      150
`define RTM_EXIT_NS       150
`define RTM_SETTLE_S_NS   150
`define RTM_SETTLE_L_NS   250
`define RTM_CYC(ns)       ((((ns) * 1000) + `RTM_CLK_PS - 1) / `RTM_CLK_PS)
`define RTM_ENTRY_CYC     `RTM_CYC(`RTM_ENTRY_NS)
`define RTM_EXIT_CYC      `RTM_CYC(`RTM_EXIT_NS)
`define RTM_SETTLE_S_CYC  `RTM_CYC(`RTM_SETTLE_S_NS)
`define RTM_SETTLE_L_CYC  `RTM_CYC(`RTM_SETTLE_L_NS)
`define RTM_BIG_STEP      6'h04
`endif

// File: rtm_pkg.sv
// Purpose: shared types for the reference training mode ends
// Assumes: nothing
// Notes:   command codes on the command bus
package rtm_pkg;
  typedef enum logic [2:0] {
    RTM_CMD_DES, RTM_CMD_ACT, RTM_CMD_WR, RTM_CMD_WRA,
    RTM_CMD_RD, RTM_CMD_RDA, RTM_CMD_PRE, RTM_CMD_MRS
  } rtm_cmd_type;
endpackage : rtm_pkg

// File: rtm_if.sv
// Purpose: command link between controller and memory device
// Assumes: one clock, commands valid for one cycle
// Notes:   mrs_data carries the training mode register image
`timescale 1ns/1ps
interface rtm_if;
  rtm_pkg::rtm_cmd_type cmd;
  logic [7:0]           mrs_data;
  logic                 per_device_addressing;
  modport ctrl (output cmd, output mrs_data, output per_device_addressing);
  modport dev  (input cmd, input mrs_data, input per_device_addressing);
endinterface : rtm_if

// File: rtm_device.sv
// Purpose: device end; enters, runs and exits reference training mode
// Assumes: controller keeps the command timing
// Notes:   outputs give the operating range and code
// How it works
// - enable bit write enters, range latched
// - value field ignored on entry
// - controller waits entry interval after entry
// - only listed commands while training
// - dummy writes accepted before first adjust
// - value writes keep enable, same range
// - enable zero leaves range, value untouched
// - controller waits settling after each value
// - per-device addressing allows only mode writes
// - last written range/value kept at exit
// - exit only when idle, banks precharged
// - only deselect until exit interval passes
// - range chosen only at entry
// - final value write then enable zero
// - settling elapses before disable command
// - range bit picks 60 or 45 percent
// - codes above 110010 reserved
`timescale 1ns/1ps
`include "rtm_consts.svh"
module rtm_device (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // command link
  rtm_if.dev              link,
  // user side
  output logic            training_on,
  output logic            ref_range,
  output logic [5:0]      ref_code,
  output logic            first_adjust_done,
  output logic            dummy_write,
  output logic            code_reserved
);
  logic       act_q, act_d;
  logic       rng_q, rng_d;
  logic [5:0] val_q, val_d;
  logic       adj_q, adj_d;
  logic       dw_q,  dw_d;
  logic       rsv_q, rsv_d;
  logic       mrs;

  assign mrs = (link.cmd == rtm_pkg::RTM_CMD_MRS);

  // next state of the training register image
  always_comb
  begin
    act_d = act_q;
    rng_d = rng_q;
    val_d = val_q;
    adj_d = adj_q;
    rsv_d = 1'b0;
    dw_d  = act_q && !adj_q && (link.cmd == rtm_pkg::RTM_CMD_WR);
    if (mrs && link.mrs_data[`RTM_EN_BIT])
    begin
      if (!act_q)
      begin
        act_d = 1'b1;
        rng_d = link.mrs_data[`RTM_RANGE_BIT];
        // value field is a don't care on entry
        val_d = val_q;
      end
      else
      begin
        // range held from entry; a changed bit is illegal and dropped
        val_d = link.mrs_data[`RTM_VAL_MSB:0];
        adj_d = 1'b1;
        rsv_d = link.mrs_data[`RTM_VAL_MSB:0] > `RTM_CODE_MAX;
      end
    end
    else if (mrs && act_q)
    begin
      act_d = 1'b0;
    end
  end

  // registers; adjust flag survives exit (first pass only)
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      act_q <= 1'b0;
      rng_q <= 1'b0;
      val_q <= 6'h00;
      adj_q <= 1'b0;
      dw_q  <= 1'b0;
      rsv_q <= 1'b0;
    end
    else
    begin
      act_q <= act_d;
      rng_q <= rng_d;
      val_q <= val_d;
      adj_q <= adj_d;
      dw_q  <= dw_d;
      rsv_q <= rsv_d;
    end
  end

  assign training_on       = act_q;
  assign ref_range         = rng_q;
  assign ref_code          = val_q;
  assign first_adjust_done = adj_q;
  assign dummy_write       = dw_q;
  assign code_reserved     = rsv_q;
endmodule : rtm_device

// File: rtm_props.sv
// Purpose: assertions on the command link between the two ends
// Assumes: one clock domain, sync active low reset
// Notes:   device outputs watched beside the link signals
`timescale 1ns/1ps
module rtm_props (
  // clock and reset
  input wire logic                 sys_clk,
  input wire logic                 rst_n,
  // link and device state
  input wire rtm_pkg::rtm_cmd_type cmd,
  input wire logic [7:0]           mrs_data,
  input wire logic                 per_device_addressing,
  input wire logic                 training_on,
  input wire logic                 ref_range,
  input wire logic [5:0]           ref_code
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // command decode; entry only counts from the idle mode
  wire is_mrs = cmd == rtm_pkg::RTM_CMD_MRS;
  wire des    = cmd == rtm_pkg::RTM_CMD_DES;
  wire entry  = is_mrs && mrs_data[7] && !training_on;
  wire setv   = is_mrs && mrs_data[7] && training_on;
  wire quit   = is_mrs && !mrs_data[7] && training_on;
  // 18 idle cycles: split since repetition counts stay small
  sequence quiet;
    des[*8] ##1 des[*8] ##1 des[*2];
  endsequence
  chk_entry_on: assert property (entry |=> training_on && ref_range == $past(mrs_data[6]))
    else $error("entry not taken");
  chk_entry_code: assert property (entry |=> $stable(ref_code))
    else $error("code moved on entry");
  chk_entry_wait: assert property (entry |=> quiet)
    else $error("command inside entry wait");
  chk_value_set: assert property (setv && mrs_data[5:0] <= 6'h32
    |=> ref_code == $past(mrs_data[5:0]))
    else $error("value write lost");
  chk_range_same: assert property (setv |-> mrs_data[6] == ref_range)
    else $error("range changed in mode");
  chk_exit_keep: assert property (quit |=> !training_on && $stable({ref_range, ref_code}))
    else $error("exit disturbed setting");
  chk_exit_wait: assert property (quit |=> quiet)
    else $error("command inside exit wait");
  chk_addr_mrs: assert property (per_device_addressing |-> des || is_mrs)
    else $error("non mode command under device addressing");
  chk_code_hold: assert property (!is_mrs |=> $stable(ref_code))
    else $error("code moved without write");
endmodule : rtm_props

// File: testbench.sv
// Purpose: drives a controller/device pair and a bench-driven device
// Assumes: 125 MHz sys_clk, reset held 12 cycles
// Notes:   pass window 0x0a..0x14 gives a midpoint of 0x0f
`timescale 1ns/1ps
`include "rtm_consts.svh"
module testbench;
  logic       sys_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic       start = 1'b0;
  logic       range_sel = 1'b0;
  logic       per_device_addressing = 1'b0;
  logic       pass_in;
  logic       done;
  logic       on1, rg1, on2, rg2, dw2, cr2, fa2, busy;
  logic [5:0] final_code, code1, code2;
  int         n_fail = 0;
  int         checks_done = 0;
  rtm_if l1();
  rtm_if l2();
  always #4 sys_clk = ~sys_clk;
  // pass only inside a window so the midpoint is known
  assign pass_in = code1 >= 6'h0a && code1 <= 6'h14;
  rtm_ctrl rtm_ctrl_i (.sys_clk, .rst_n, .link(l1), .start, .range_sel,
    .per_device_addressing, .pass_in, .busy, .done, .final_code);
  rtm_device rtm_device_i (.sys_clk, .rst_n, .link(l1), .training_on(on1), .ref_range(rg1),
    .ref_code(code1), .first_adjust_done(), .dummy_write(), .code_reserved());
  // second device faces the bench, which may break controller timing
  rtm_device rtm_device_i2 (.sys_clk, .rst_n, .link(l2), .training_on(on2), .ref_range(rg2),
    .ref_code(code2), .first_adjust_done(fa2), .dummy_write(dw2), .code_reserved(cr2));
  rtm_props rtm_props_i (.sys_clk, .rst_n, .cmd(l1.cmd), .mrs_data(l1.mrs_data),
    .per_device_addressing(l1.per_device_addressing), .training_on(on1), .ref_range(rg1),
    .ref_code(code1));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic finish_test;
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test
  // one command cycle; data inverted after so stale values never match
  task automatic send(input rtm_pkg::rtm_cmd_type c, input logic [7:0] d);
    @(posedge sys_clk);
    #1 l2.cmd = c;
    l2.mrs_data = d;
    @(posedge sys_clk);
    #1 l2.cmd = rtm_pkg::RTM_CMD_DES;
    l2.mrs_data = ~d;
  endtask : send
  // full controller pass, bounded wait on done
  task automatic run(input logic r, input logic p, input logic [7:0] exp);
    int i;
    @(posedge sys_clk);
    #1 range_sel = r;
    per_device_addressing = p;
    start = 1'b1;
    @(posedge sys_clk);
    #1 start = 1'b0;
    chk({7'h00, busy}, 8'h01);
    i = 0;
    while (done !== 1'b1 && i < 20000)
    begin
      @(posedge sys_clk);
      #1 i++;
    end
    if (done !== 1'b1)
    begin
      n_fail++;
      finish_test();
    end
    chk({2'b00, final_code}, {2'b00, exp[5:0]});
    chk({7'h00, busy}, 8'h00);
    repeat (25) @(posedge sys_clk);
    chk({on1, rg1, code1}, exp);
  endtask : run
  initial
  begin
    l2.cmd = rtm_pkg::RTM_CMD_DES;
    l2.mrs_data = 8'h00;
    l2.per_device_addressing = 1'b0;
    repeat (12) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    send(rtm_pkg::RTM_CMD_MRS, 8'hc5);
    chk({on2, rg2, code2}, 8'hc0);
    chk({7'h00, fa2}, 8'h00);
    repeat (`RTM_ENTRY_CYC) @(posedge sys_clk);
    send(rtm_pkg::RTM_CMD_WR, 8'h00);
    chk({7'h00, dw2}, 8'h01);
    send(rtm_pkg::RTM_CMD_MRS, 8'hea);
    chk({on2, rg2, code2}, 8'hea);
    chk({7'h00, fa2}, 8'h01);
    chk({7'h00, cr2}, 8'h00);
    send(rtm_pkg::RTM_CMD_MRS, 8'hf3);
    chk({7'h00, cr2}, 8'h01);
    send(rtm_pkg::RTM_CMD_MRS, 8'h8a);
    chk({on2, rg2, code2}, 8'hca);
    send(rtm_pkg::RTM_CMD_WR, 8'h00);
    chk({7'h00, dw2}, 8'h00);
    // let the last step settle before the disabling write
    repeat (`RTM_SETTLE_L_CYC) @(posedge sys_clk);
    send(rtm_pkg::RTM_CMD_MRS, 8'h15);
    chk({on2, rg2, code2}, 8'h4a);
    $display("test direct writes done");
    run(1'b1, 1'b0, 8'h4f);
    $display("test sweep done");
    run(1'b0, 1'b1, 8'h00);
    $display("test addressed pass done");
    finish_test();
  end
endmodule : testbench
